// file: src/mdic_top.v
// Runtime mailboxes, doorbells and interrupt control/status reached from both buses
`include "mdic_map.vh"

module mdic_top (
   input wire mclk_i,
   input wire reset_n_i,
   input wire pci_wr_i,
   input wire pci_rd_i,
   input wire [7:0] pci_addr_i,
   input wire [31:0] pci_wdata_i,
   output wire [31:0] pci_rdata_o,
   input wire loc_wr_i,
   input wire loc_rd_i,
   input wire [7:0] loc_addr_i,
   input wire [31:0] loc_wdata_i,
   output wire [31:0] loc_rdata_o,
   input wire [1:0] bus_style_i,
   input wire host_mode_i,
   input wire [1:0] pm_state_i,
   input wire loc_parity_err_i,
   input wire pci_abort_act_i,
   input wire serr_seen_i,
   input wire pci_parity_err_i,
   input wire oq_overflow_i,
   output wire local_irq_out_n_o,
   output wire local_system_error_out_n_o,
   output wire transfer_error_ack_en_o,
   output wire pci_serr_n_o,
   output wire pci_inta_n_o
);

   ////////////////////////////////////////////////////////////////////////
   // Storage

   reg [31:0] general_mailbox_six_q;
   reg [31:0] general_mailbox_seven_q;
   reg [31:0] ctl_q;
   reg pm_irq_q;
   reg par_st_q;
   reg mbx_irq_q;
   reg [1:0] pm_prev_q;
   reg pm_valid_q;
   reg serr_n_q;
   reg inta_n_q;
   reg [31:0] pci_rdata_q;
   reg [31:0] loc_rdata_q;
   reg [31:0] int_img;

   wire [31:0] p2l_bits;
   wire [31:0] l2p_bits;

   ////////////////////////////////////////////////////////////////////////
   // Address decode, one set per bus

   wire pci_mb6_we;
   wire pci_mb7_we;
   wire pci_p2l_we;
   wire pci_l2p_we;
   wire pci_int_we;
   wire loc_mb6_we;
   wire loc_mb7_we;
   wire loc_p2l_we;
   wire loc_l2p_we;
   wire loc_int_we;
   wire pci_mb03_we;
   wire loc_mb03_rd;

   assign pci_mb6_we = pci_wr_i & (pci_addr_i == `MDIC_PCI_GENERAL_MAILBOX_SIX);
   assign pci_mb7_we = pci_wr_i & (pci_addr_i == `MDIC_PCI_GENERAL_MAILBOX_SEVEN);
   assign pci_p2l_we = pci_wr_i & (pci_addr_i == `MDIC_PCI_P2L);
   assign pci_l2p_we = pci_wr_i & (pci_addr_i == `MDIC_PCI_L2P);
   assign pci_int_we = pci_wr_i & (pci_addr_i == `MDIC_PCI_INTERRUPT_CONTROL_STATUS);

   assign loc_mb6_we = loc_wr_i & (loc_addr_i == `MDIC_LOC_GENERAL_MAILBOX_SIX);
   assign loc_mb7_we = loc_wr_i & (loc_addr_i == `MDIC_LOC_GENERAL_MAILBOX_SEVEN);
   assign loc_p2l_we = loc_wr_i & (loc_addr_i == `MDIC_LOC_P2L);
   assign loc_l2p_we = loc_wr_i & (loc_addr_i == `MDIC_LOC_L2P);
   assign loc_int_we = loc_wr_i & (loc_addr_i == `MDIC_LOC_INTERRUPT_CONTROL_STATUS);

   // Mailboxes 0-3 live elsewhere; only their access strobes are watched here
   assign pci_mb03_we = pci_wr_i & ((pci_addr_i == `MDIC_PCI_MB0)
      | (pci_addr_i == `MDIC_PCI_MB1)
      | (pci_addr_i == `MDIC_PCI_MB2)
      | (pci_addr_i == `MDIC_PCI_MB3)
      | (pci_addr_i == `MDIC_PCI_MB0_ALT)
      | (pci_addr_i == `MDIC_PCI_MB1_ALT));
   assign loc_mb03_rd = loc_rd_i & ((loc_addr_i == `MDIC_LOC_MB0)
      | (loc_addr_i == `MDIC_LOC_MB1)
      | (loc_addr_i == `MDIC_LOC_MB2)
      | (loc_addr_i == `MDIC_LOC_MB3));

   ////////////////////////////////////////////////////////////////////////
   // General mailboxes; a PCI write wins a same-cycle collision

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         general_mailbox_six_q <= `MDIC_RST_WORD;
      end else if (pci_mb6_we) begin
         general_mailbox_six_q <= pci_wdata_i;
      end else if (loc_mb6_we) begin
         general_mailbox_six_q <= loc_wdata_i;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         general_mailbox_seven_q <= `MDIC_RST_WORD;
      end else if (pci_mb7_we) begin
         general_mailbox_seven_q <= pci_wdata_i;
      end else if (loc_mb7_we) begin
         general_mailbox_seven_q <= loc_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Doorbells

   mdic_dbell u_host_to_local (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .set_we_i(pci_p2l_we),
      .set_i(pci_wdata_i),
      .clr_we_i(loc_p2l_we),
      .clr_i(loc_wdata_i),
      .bits_o(p2l_bits)
   );

   mdic_dbell u_local_to_host (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .set_we_i(loc_l2p_we),
      .set_i(loc_wdata_i),
      .clr_we_i(pci_l2p_we),
      .clr_i(pci_wdata_i),
      .bits_o(l2p_bits)
   );

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         inta_n_q <= 1'b1;
      end else begin
         inta_n_q <= ~(ctl_q[`MDIC_B_PCI_IE] & ctl_q[`MDIC_B_PDB_IE]
            & (|l2p_bits));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt control bits, written from either bus

   wire int_we;
   wire [31:0] int_wdata;

   assign int_we = pci_int_we | loc_int_we;
   assign int_wdata = pci_int_we ? pci_wdata_i : loc_wdata_i;

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctl_q <= `MDIC_CTL_RST;
      end else if (int_we) begin
         ctl_q <= int_wdata & `MDIC_CTL_MASK;
      end
   end

   // SERR is a single-cycle pulse, armed only from a stored 0
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         serr_n_q <= 1'b1;
      end else begin
         serr_n_q <= ~(int_we & int_wdata[`MDIC_B_SERR]
            & ~ctl_q[`MDIC_B_SERR]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power state watch

   wire pm_chg;
   wire pm_clr;

   // First sample after reset is only captured, so a non-D0 strap is not an event
   assign pm_chg = pm_valid_q & (pm_state_i != pm_prev_q);
   assign pm_clr = (pci_int_we & pci_wdata_i[`MDIC_B_PM_ST]
      & (pm_state_i == `MDIC_PM_D0))
      | (loc_int_we & loc_wdata_i[`MDIC_B_PM_ST]);

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pm_prev_q <= `MDIC_PM_D0;
         pm_valid_q <= 1'b0;
      end else begin
         pm_prev_q <= pm_state_i;
         pm_valid_q <= 1'b1;
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pm_irq_q <= 1'b0;
      end else if (pm_chg) begin
         pm_irq_q <= 1'b1;
      end else if (pm_clr) begin
         pm_irq_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Local parity error status

   wire par_clr;

   assign par_clr = (pci_int_we & pci_wdata_i[`MDIC_B_PAR_ST])
      | (loc_int_we & loc_wdata_i[`MDIC_B_PAR_ST]);

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         par_st_q <= 1'b0;
      end else if (loc_parity_err_i) begin
         par_st_q <= 1'b1;
      end else if (par_clr) begin
         par_st_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mailbox 0-3 notification, acknowledged by a local read

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mbx_irq_q <= 1'b0;
      end else if (pci_mb03_we && ctl_q[`MDIC_B_MBX_EN]) begin
         mbx_irq_q <= 1'b1;
      end else if (loc_mb03_rd) begin
         mbx_irq_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt routing

   wire err_evt;

   // Event levels are held by their owners until serviced there
   assign err_evt = (host_mode_i & serr_seen_i) | pci_parity_err_i
      | oq_overflow_i;

   mdic_irq_route u_route (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .bus_style_i(bus_style_i),
      .ctl_i(ctl_q),
      .ldb_i(|p2l_bits),
      .mbx_i(mbx_irq_q),
      .pm_i(pm_irq_q),
      .par_i(par_st_q),
      .abort_i(pci_abort_act_i),
      .err_i(err_evt),
      .lint_n_o(local_irq_out_n_o),
      .local_system_error_out_n_n_o(local_system_error_out_n_o),
      .tea_en_o(transfer_error_ack_en_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read images

   always @* begin
      int_img = ctl_q;
      int_img[`MDIC_B_PM_ST] = pm_irq_q;
      int_img[`MDIC_B_PAR_ST] = par_st_q;
      int_img[`MDIC_B_PDB_ACT] = ctl_q[`MDIC_B_PDB_IE] & (|l2p_bits);
      int_img[`MDIC_B_LDB_ACT] = ctl_q[`MDIC_B_LDB_IE] & (|p2l_bits);
   end

   function [31:0] rd_img;
      input [7:0] a;
      input loc;
      begin
         if (a == (loc ? `MDIC_LOC_GENERAL_MAILBOX_SIX : `MDIC_PCI_GENERAL_MAILBOX_SIX)) begin
            rd_img = general_mailbox_six_q;
         end else if (a == (loc ? `MDIC_LOC_GENERAL_MAILBOX_SEVEN : `MDIC_PCI_GENERAL_MAILBOX_SEVEN)) begin
            rd_img = general_mailbox_seven_q;
         end else if (a == (loc ? `MDIC_LOC_P2L : `MDIC_PCI_P2L)) begin
            rd_img = p2l_bits;
         end else if (a == (loc ? `MDIC_LOC_L2P : `MDIC_PCI_L2P)) begin
            rd_img = l2p_bits;
         end else if (a == (loc ? `MDIC_LOC_INTERRUPT_CONTROL_STATUS : `MDIC_PCI_INTERRUPT_CONTROL_STATUS)) begin
            rd_img = int_img;
         end else begin
            rd_img = `MDIC_RST_WORD;
         end
      end
   endfunction

   // Read data is captured on the strobe and held until the next read
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pci_rdata_q <= `MDIC_RST_WORD;
      end else if (pci_rd_i) begin
         pci_rdata_q <= rd_img(pci_addr_i, 1'b0);
      end
   end

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         loc_rdata_q <= `MDIC_RST_WORD;
      end else if (loc_rd_i) begin
         loc_rdata_q <= rd_img(loc_addr_i, 1'b1);
      end
   end

   assign pci_rdata_o = pci_rdata_q;
   assign loc_rdata_o = loc_rdata_q;
   assign pci_serr_n_o = serr_n_q;
   assign pci_inta_n_o = inta_n_q;

endmodule // mdic_top

// file: src/mdic_map.vh
// Register offsets, field positions, reset values and codes of the mailbox/doorbell block
// What this block does
// - Mailboxes six and seven: 32-bit, read/write, reset zero
// - Host doorbell write can raise local interrupt
// - Host writes 1 set host-to-local doorbell bits
// - Local reads doorbell; local write-1 clears bits
// - Local doorbell write can raise PCI interrupt
// - Local-to-host: local 1 sets, PCI 1 clears
// - First style: bit 0 enables TEA, parity-to-local-irq
// - Other styles: bit 0 parity/abort to system error
// - Bit 1 routes SERR, parity, overflow events
// - Writing 1 to bit 2 while 0 pulses SERR
// - Mailbox 0-3 PCI write irq; local read clears
// - Bit 4 enables power-state-change local interrupt
// - Bit 5 sets on power-state change, write-1 clears
// - PCI clears bit 5 only in D0
// - Bit 6 gates parity signalling, needs bit 0
// - Bit 7 always latches parity error; write-1 clears
// - All registers writable from both buses
// - Bit 16 gates local interrupt, resets to 1
`ifndef MDIC_MAP_VH
`define MDIC_MAP_VH

`define MDIC_PCI_GENERAL_MAILBOX_SIX 8'h58
`define MDIC_PCI_GENERAL_MAILBOX_SEVEN 8'h5C
`define MDIC_PCI_P2L 8'h60
`define MDIC_PCI_L2P 8'h64
`define MDIC_PCI_INTERRUPT_CONTROL_STATUS 8'h68
`define MDIC_LOC_GENERAL_MAILBOX_SIX 8'hD8
`define MDIC_LOC_GENERAL_MAILBOX_SEVEN 8'hDC
`define MDIC_LOC_P2L 8'hE0
`define MDIC_LOC_L2P 8'hE4
`define MDIC_LOC_INTERRUPT_CONTROL_STATUS 8'hE8

`define MDIC_PCI_MB0 8'h40
`define MDIC_PCI_MB1 8'h44
`define MDIC_PCI_MB2 8'h48
`define MDIC_PCI_MB3 8'h4C
`define MDIC_PCI_MB0_ALT 8'h78
`define MDIC_PCI_MB1_ALT 8'h7C
`define MDIC_LOC_MB0 8'hC0
`define MDIC_LOC_MB1 8'hC4
`define MDIC_LOC_MB2 8'hC8
`define MDIC_LOC_MB3 8'hCC

`define MDIC_B_SRC0 0
`define MDIC_B_SRC1 1
`define MDIC_B_SERR 2
`define MDIC_B_MBX_EN 3
`define MDIC_B_PM_EN 4
`define MDIC_B_PM_ST 5
`define MDIC_B_PAR_EN 6
`define MDIC_B_PAR_ST 7
`define MDIC_B_PCI_IE 8
`define MDIC_B_PDB_IE 9
`define MDIC_B_PDB_ACT 13
`define MDIC_B_LIO_EN 16
`define MDIC_B_LDB_IE 17
`define MDIC_B_LDB_ACT 20

`define MDIC_CTL_MASK 32'h0003035F
`define MDIC_CTL_RST 32'h00010100
`define MDIC_RST_WORD 32'h00000000

`define MDIC_STYLE_M 2'h0
`define MDIC_STYLE_C 2'h1
`define MDIC_STYLE_J 2'h2
`define MDIC_PM_D0 2'h0

`endif

// file: src/mdic_dbell.v
// One 32-bit doorbell: one side sets bits with 1s, the other clears them with 1s
module mdic_dbell (
   input wire mclk_i,
   input wire reset_n_i,
   input wire set_we_i,
   input wire [31:0] set_i,
   input wire clr_we_i,
   input wire [31:0] clr_i,
   output wire [31:0] bits_o
);

   reg [31:0] bits_q;
   genvar gi;

   generate
      for (gi = 0; gi < 32; gi = gi + 1) begin : g_bit
         always @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               bits_q[gi] <= 1'b0;
            end else if (set_we_i && set_i[gi]) begin
               // A ring in the same cycle as an acknowledge must not be lost
               bits_q[gi] <= 1'b1;
            end else if (clr_we_i && clr_i[gi]) begin
               bits_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign bits_o = bits_q;

endmodule // mdic_dbell

// file: src/mdic_irq_route.v
// Routes interrupt sources to the local interrupt, system-error and TEA enable outputs
`include "mdic_map.vh"

module mdic_irq_route (
   input wire mclk_i,
   input wire reset_n_i,
   input wire [1:0] bus_style_i,
   input wire [31:0] ctl_i,
   input wire ldb_i,
   input wire mbx_i,
   input wire pm_i,
   input wire par_i,
   input wire abort_i,
   input wire err_i,
   output reg lint_n_o,
   output reg local_system_error_out_n_n_o,
   output reg tea_en_o
);

   wire is_m;
   wire par_path;
   wire err_path;
   wire lint_src;
   wire local_system_error_out_n_src;

   assign is_m = (bus_style_i == `MDIC_STYLE_M);
   // Parity signalling needs both the master source enable and its own enable
   assign par_path = ctl_i[`MDIC_B_SRC0] & ctl_i[`MDIC_B_PAR_EN] & par_i;
   assign err_path = ctl_i[`MDIC_B_SRC1] & err_i;
   assign lint_src = (ctl_i[`MDIC_B_LDB_IE] & ldb_i)
      | (ctl_i[`MDIC_B_MBX_EN] & mbx_i)
      | (ctl_i[`MDIC_B_PM_EN] & pm_i)
      | (is_m & (par_path | err_path));
   assign local_system_error_out_n_src = ~is_m & (par_path | err_path
      | (ctl_i[`MDIC_B_SRC0] & abort_i));

   ////////////////////////////////////////////////////////////////////////
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lint_n_o <= 1'b1;
         local_system_error_out_n_n_o <= 1'b1;
         tea_en_o <= 1'b0;
      end else begin
         lint_n_o <= ~(ctl_i[`MDIC_B_LIO_EN] & lint_src);
         local_system_error_out_n_n_o <= ~local_system_error_out_n_src;
         tea_en_o <= is_m & ctl_i[`MDIC_B_SRC0];
      end
   end

endmodule // mdic_irq_route

// file: sim/mdic_assertions.sv
// Port-level checks of the mailbox, doorbell and interrupt control block
module mdic_assertions (
   input wire mclk_i,
   input wire reset_n_i,
   input wire pci_wr_i,
   input wire pci_rd_i,
   input wire [7:0] pci_addr_i,
   input wire [31:0] pci_wdata_i,
   input wire [31:0] pci_rdata_o,
   input wire loc_wr_i,
   input wire loc_rd_i,
   input wire [7:0] loc_addr_i,
   input wire [31:0] loc_wdata_i,
   input wire [31:0] loc_rdata_o,
   input wire [1:0] bus_style_i,
   input wire local_irq_out_n_o,
   input wire local_system_error_out_n_o,
   input wire transfer_error_ack_en_o,
   input wire pci_serr_n_o,
   input wire pci_inta_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   wire ctl_w2 = (pci_wr_i && pci_addr_i == 8'h68 && pci_wdata_i[2])
      || (loc_wr_i && loc_addr_i == 8'hE8 && loc_wdata_i[2]);
   ////////////////////////////////////////////////////////////
   sequence s_mb6_wr;
      pci_wr_i && pci_addr_i == 8'h58;
   endsequence
   sequence s_pci_rd;
      pci_rd_i && pci_addr_i == 8'h58 && !pci_wr_i && !loc_wr_i;
   endsequence
   sequence s_loc_rd;
      loc_rd_i && loc_addr_i == 8'hD8 && !pci_wr_i && !loc_wr_i;
   endsequence
   sequence s_l2p_clr;
      pci_wr_i && pci_addr_i == 8'h64 && pci_wdata_i == 32'hFFFFFFFF
         && !(loc_wr_i && loc_addr_i == 8'hE4);
   endsequence
   sequence s_lint_off;
      pci_wr_i && pci_addr_i == 8'h68 && !pci_wdata_i[16];
   endsequence
   // Read data is allowed two edges, so the check waits for the later one
   property p_mbox;
      s_mb6_wr ##1 s_pci_rd ##1 !pci_rd_i |=> pci_rdata_o == $past(pci_wdata_i, 3);
   endproperty
   property p_xbus;
      s_mb6_wr ##1 s_loc_rd ##1 !loc_rd_i |=> loc_rdata_o == $past(pci_wdata_i, 3);
   endproperty
   property p_inta_clr;
      s_l2p_clr |=> ##1 pci_inta_n_o;
   endproperty
   property p_lint_gate;
      s_lint_off |=> ##1 local_irq_out_n_o;
   endproperty
   property p_serr_cause;
      !pci_serr_n_o |-> $past(ctl_w2) || $past(ctl_w2, 2);
   endproperty
   property p_serr_pulse;
      !pci_serr_n_o |=> pci_serr_n_o;
   endproperty
   property p_tea;
      transfer_error_ack_en_o |-> $past(bus_style_i) == 2'h0;
   endproperty
   property p_local_system_error_out_n_m;
      $past(bus_style_i) == 2'h0 |-> local_system_error_out_n_o;
   endproperty
   a_mbox: assert property (p_mbox) else $error("mailbox read mismatch");
   a_xbus: assert property (p_xbus) else $error("cross-bus read mismatch");
   a_inta_clr: assert property (p_inta_clr) else $error("inta stuck");
   a_lint_gate: assert property (p_lint_gate) else $error("lint not gated");
   a_serr_cause: assert property (p_serr_cause) else $error("serr no cause");
   a_serr_pulse: assert property (p_serr_pulse) else $error("serr too long");
   a_tea: assert property (p_tea) else $error("tea in wrong style");
   a_local_system_error_out_n_m: assert property (p_local_system_error_out_n_m) else $error("local_system_error_out_n in first style");
endmodule // mdic_assertions

bind mdic_top mdic_assertions chk_i (.mclk_i, .reset_n_i, .pci_wr_i, .pci_rd_i,
   .pci_addr_i, .pci_wdata_i, .pci_rdata_o, .loc_wr_i, .loc_rd_i, .loc_addr_i,
   .loc_wdata_i, .loc_rdata_o, .bus_style_i, .local_irq_out_n_o,
   .local_system_error_out_n_o, .transfer_error_ack_en_o, .pci_serr_n_o,
   .pci_inta_n_o);

// file: sim/mdic_hosts.sv
// Bus masters of the PCI host and the local processor
module mdic_hosts (
   input wire mclk_i,
   output logic pci_wr_o,
   output logic pci_rd_o,
   output logic [7:0] pci_addr_o,
   output logic [31:0] pci_wdata_o,
   input wire [31:0] pci_rdata_i,
   output logic loc_wr_o,
   output logic loc_rd_o,
   output logic [7:0] loc_addr_o,
   output logic [31:0] loc_wdata_o,
   input wire [31:0] loc_rdata_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {pci_wr_o, pci_rd_o, loc_wr_o, loc_rd_o} = 4'h0;
   initial {pci_addr_o, loc_addr_o, pci_wdata_o, loc_wdata_o} = 80'h0;
   // One access with an idle cycle after it; read data is taken two edges on
   task acc(input bit l, input bit w, input [7:0] a, input [31:0] d, output [31:0] q);
      if (l) begin
         loc_wr_o = w;
         loc_rd_o = !w;
         loc_addr_o = a;
         loc_wdata_o = d;
      end else begin
         pci_wr_o = w;
         pci_rd_o = !w;
         pci_addr_o = a;
         pci_wdata_o = d;
      end
      @(posedge mclk_i) #2;
      {pci_wr_o, pci_rd_o, loc_wr_o, loc_rd_o} = 4'h0;
      @(posedge mclk_i) #2;
      q = l ? loc_rdata_i : pci_rdata_i;
   endtask
   // PCI writes the sixth mailbox, then either bus reads it on the very next edge
   task w2r(input bit l, input [31:0] d, output [31:0] q);
      pci_wr_o = 1'h1;
      pci_addr_o = 8'h58;
      pci_wdata_o = d;
      @(posedge mclk_i) #2;
      pci_wr_o = 1'h0;
      loc_addr_o = 8'hD8;
      if (l) loc_rd_o = 1'h1;
      else pci_rd_o = 1'h1;
      @(posedge mclk_i) #2;
      {pci_rd_o, loc_rd_o} = 2'h0;
      @(posedge mclk_i) #2;
      q = l ? loc_rdata_i : pci_rdata_i;
   endtask
endmodule // mdic_hosts

// file: sim/mailbox_doorbell_irq_ctrl_test.sv
// Self-checking bench of the mailbox, doorbell and interrupt control block
module mailbox_doorbell_irq_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 0, reset_n_i = 0, host_mode_i = 1, loc_parity_err_i = 0;
   logic pci_abort_act_i = 0, serr_seen_i = 0, pci_parity_err_i = 0, oq_overflow_i = 0;
   logic [1:0] bus_style_i = 2'h0, pm_state_i = 2'h0;
   wire pci_wr_i, pci_rd_i, loc_wr_i, loc_rd_i, local_irq_out_n_o, pci_serr_n_o;
   wire local_system_error_out_n_o, transfer_error_ack_en_o, pci_inta_n_o;
   wire [7:0] pci_addr_i, loc_addr_i;
   wire [31:0] pci_wdata_i, loc_wdata_i, pci_rdata_o, loc_rdata_o;
   int err_count = 0, n_tests = 0;
   logic [31:0] q;
   int n;
   mdic_top uut (.mclk_i, .reset_n_i, .pci_wr_i, .pci_rd_i, .pci_addr_i, .pci_wdata_i,
      .pci_rdata_o, .loc_wr_i, .loc_rd_i, .loc_addr_i, .loc_wdata_i, .loc_rdata_o,
      .bus_style_i, .host_mode_i, .pm_state_i, .loc_parity_err_i, .pci_abort_act_i,
      .serr_seen_i, .pci_parity_err_i, .oq_overflow_i, .local_irq_out_n_o,
      .local_system_error_out_n_o, .transfer_error_ack_en_o, .pci_serr_n_o, .pci_inta_n_o);
   mdic_hosts h (.mclk_i, .pci_wr_o(pci_wr_i), .pci_rd_o(pci_rd_i), .pci_addr_o(pci_addr_i),
      .pci_wdata_o(pci_wdata_i), .pci_rdata_i(pci_rdata_o), .loc_wr_o(loc_wr_i),
      .loc_rd_o(loc_rd_i), .loc_addr_o(loc_addr_i), .loc_wdata_o(loc_wdata_i),
      .loc_rdata_i(loc_rdata_o));
   initial forever #12.5 mclk_i = !mclk_i;
   ////////////////////////////////////////////////////////////
   task chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", s, exp, got);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task cyc(input int k);
      repeat (k) @(posedge mclk_i) #2;
   endtask
   task w(input bit l, input [7:0] a, input [31:0] d);
      h.acc(l, 1'h1, a, d, q);
   endtask
   task r(input bit l, input [7:0] a, input [31:0] e, input string s);
      h.acc(l, 1'h0, a, 32'h0, q);
      chk(s, q, e);
   endtask
   task rst;
      reset_n_i = 0;
      cyc(10);
      reset_n_i = 1;
   endtask
   ////////////////////////////////////////////////////////////
   task s_reset;
      r(0, 8'h58, 32'h0, "mb6");
      r(1, 8'hDC, 32'h0, "mb7");
      r(0, 8'h60, 32'h0, "p2l");
      r(1, 8'hE4, 32'h0, "l2p");
      r(1, 8'hE8, 32'h00010100, "ctl");
      r(1, 8'hF0, 32'h0, "unmapped");
      chk("outs", {local_irq_out_n_o, local_system_error_out_n_o, transfer_error_ack_en_o,
         pci_serr_n_o, pci_inta_n_o}, 32'h1B);
   endtask
   task s_mbox;
      h.w2r(0, 32'hA5C30F96, q);
      chk("mb6 pci", q, 32'hA5C30F96);
      h.w2r(1, 32'h5A3CF069, q);
      chk("mb6 loc", q, 32'h5A3CF069);
      w(1, 8'hDC, 32'hFFFF0001);
      r(0, 8'h5C, 32'hFFFF0001, "mb7");
   endtask
   task s_p2l;
      w(0, 8'h68, 32'h00030100);
      w(0, 8'h60, 32'h81);
      r(1, 8'hE0, 32'h81, "p2l set");
      chk("lint db", local_irq_out_n_o, 32'h0);
      w(0, 8'h60, 32'h2);
      r(1, 8'hE0, 32'h83, "p2l keep");
      w(1, 8'hE0, 32'h1);
      r(0, 8'h60, 32'h82, "p2l clr");
      w(1, 8'hE0, 32'h82);
      chk("lint idle", local_irq_out_n_o, 32'h1);
   endtask
   task s_l2p;
      w(0, 8'h68, 32'h00010300);
      w(1, 8'hE4, 32'hF);
      chk("inta", pci_inta_n_o, 32'h0);
      w(0, 8'h64, 32'h5);
      r(1, 8'hE4, 32'hA, "l2p clr");
      w(0, 8'h64, 32'hFFFFFFFF);
      chk("inta off", pci_inta_n_o, 32'h1);
   endtask
   task s_serr(input [31:0] e);
      n = 0;
      fork
         w(0, 8'h68, 32'h4);
         repeat (4) begin
            @(posedge mclk_i) #2;
            if (pci_serr_n_o === 1'h0) n++;
         end
      join
      chk("serr pulses", n, e);
   endtask
   task s_par;
      w(0, 8'h68, 32'h00010041);
      chk("tea", transfer_error_ack_en_o, 32'h1);
      loc_parity_err_i = 1;
      cyc(1);
      loc_parity_err_i = 0;
      cyc(1);
      chk("lint par", local_irq_out_n_o, 32'h0);
      w(0, 8'h68, 32'h00010081);
      r(1, 8'hE8, 32'h00010001, "par clr");
      loc_parity_err_i = 1;
      cyc(1);
      loc_parity_err_i = 0;
      cyc(1);
      chk("lint nopar", local_irq_out_n_o, 32'h1);
      r(0, 8'h68, 32'h00010081, "par st");
   endtask
   task s_style(input [1:0] st);
      bus_style_i = st;
      rst;
      w(0, 8'h68, 32'h00010003);
      chk("tea off", transfer_error_ack_en_o, 32'h0);
      pci_abort_act_i = 1;
      cyc(2);
      chk("local_system_error_out_n abort", local_system_error_out_n_o, 32'h0);
      pci_abort_act_i = 0;
      w(0, 8'h68, 32'h00010102);
      for (int i = 0; i < 3; i++) begin
         {serr_seen_i, pci_parity_err_i, oq_overflow_i} = 3'h1 << i;
         cyc(2);
         chk("local_system_error_out_n ev", local_system_error_out_n_o, 32'h0);
         chk("lint ev", local_irq_out_n_o, 32'h1);
         {serr_seen_i, pci_parity_err_i, oq_overflow_i} = 3'h0;
         cyc(2);
      end
      // An observed SERR only counts while the bridge is the host
      host_mode_i = 0;
      serr_seen_i = 1;
      cyc(2);
      chk("local_system_error_out_n guest", local_system_error_out_n_o, 32'h1);
      serr_seen_i = 0;
      host_mode_i = 1;
   endtask
   task s_pm;
      w(0, 8'h68, 32'h00010110);
      pm_state_i = 2'h3;
      cyc(2);
      chk("lint pm", local_irq_out_n_o, 32'h0);
      w(0, 8'h68, 32'h00010130);
      r(0, 8'h68, 32'h00010130, "pm d3");
      pm_state_i = 2'h0;
      cyc(2);
      w(0, 8'h68, 32'h00010130);
      r(1, 8'hE8, 32'h00010110, "pm clr");
      w(0, 8'h68, 32'h10);
      pm_state_i = 2'h1;
      cyc(2);
      chk("lint gated", local_irq_out_n_o, 32'h1);
      r(0, 8'h68, 32'h30, "pm set");
   endtask
   task s_mbx;
      w(0, 8'h68, 32'h00010008);
      w(0, 8'h48, 32'h1);
      chk("lint mbx", local_irq_out_n_o, 32'h0);
      h.acc(1, 1'h0, 8'hC8, 32'h0, q);
      cyc(1);
      chk("lint mbx clr", local_irq_out_n_o, 32'h1);
   endtask
   initial begin
      #2ms;
      err_count++;
      close_out;
   end
   initial begin
      rst;
      s_reset;
      s_mbox;
      s_p2l;
      s_l2p;
      s_serr(1);
      s_serr(0);
      s_par;
      s_style(2'h1);
      s_style(2'h2);
      s_pm;
      s_mbx;
      close_out;
   end
endmodule // mailbox_doorbell_irq_ctrl_test
